// ==== dma_translator.sv ====
// Inbound DMA address translator: partition lookup, range checks, cache and walk.
`timescale 1ns/10ps
module dma_translator
    import dma_xlate_pkg::*;
#(
    parameter int CACHE_DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic translate_en,
    input wire logic walk_en,
    input wire logic partitioned_translation_mode,
    input wire logic bus_id_shift,
    input wire logic [1:0] cache_mode_code,
    input wire logic flush_req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [63:0] req_addr,
    input wire logic req_is64,
    input wire logic req_write,
    input wire logic [15:0] req_id,
    output logic resp_valid,
    output logic resp_null,
    output logic [PA_W-1:0] resp_pa,
    output logic walk_req_valid,
    output logic [PA_W-1:0] walk_req_addr,
    output logic [7:0] walk_req_slot,
    input wire logic walk_rsp_valid,
    input wire logic [ENTRY_W-1:0] walk_rsp_data,
    input wire logic walk_rsp_par,
    input wire logic walk_rsp_ue,
    input wire logic walk_rsp_dpe,
    input wire logic [7:0] walk_rsp_slot,
    input wire logic desc_we,
    input wire logic [PART_W-1:0] desc_idx,
    input wire logic [ENTRY_W-1:0] desc_wdata,
    output logic [ENTRY_W-1:0] desc_rdata,
    input wire logic map_we,
    input wire logic [PID_W-1:0] map_idx,
    input wire logic [PART_W-1:0] map_wdata,
    input wire logic [FLAG_W-1:0] flag_clear,
    output logic [FLAG_W-1:0] flags
);

    tte_cache_if cif ();

    tte_cache #(.DEPTH(CACHE_DEPTH)) u_cache (
        .clk(clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    xlate_state_e state_reg; // Sequencing state.
    xlate_state_e state_next; // Next sequencing state.
    logic [ENTRY_W-1:0] desc_reg [DESC_COUNT]; // Partition descriptor table.
    logic [PART_W-1:0] map_reg [MAP_COUNT]; // Partition ID to descriptor index table.
    logic [63:0] addr_reg; // Latched request address.
    logic is64_reg; // Latched addressing mode.
    logic write_reg; // Latched write indication.
    logic [15:0] id_reg; // Latched requester ID.
    logic [ENTRY_W-1:0] entry_reg; // Entry fetched by the walk.
    logic [7:0] slot_reg; // Slot allocated when the walk was issued.
    logic [FLAG_W-1:0] flags_reg; // Sticky error flags.
    logic [FLAG_W-1:0] flag_set; // Flags raised this cycle.
    logic null_reg; // Answer is nullified.
    logic [PA_W-1:0] pa_reg; // Answer physical address.
    logic walk_pulse_reg; // One-cycle walk request.
    logic [PA_W-1:0] walk_addr_reg; // Entry address sent with the walk.
    logic [ENTRY_W-1:0] rdata_reg; // Descriptor read-back.

    // Descriptor writes get their parity bits computed here; software's are dropped.
    wire logic par_hi = ~^{desc_wdata[DESC_VALID], desc_wdata[DESC_BASE_HI:32]};
    wire logic par_lo = ~^desc_wdata[31:0];

    // Address forming: 32-bit requests are zero-extended and never overflow.
    // The mode latched with the request decides, not the live pin, which may move on.
    wire logic [VA_W-1:0] va = is64_reg ? addr_reg[VA_W-1:0] : {8'h00, addr_reg[31:0]};
    wire logic va_oor = is64_reg && (addr_reg[62:VA_W] != 23'h000000);
    wire logic [7:0] bus_id = id_reg[15:8];
    wire logic [5:0] bus_bits = bus_id_shift ? bus_id[6:1] : bus_id[5:0];
    wire logic [PID_W-1:0] pid = {addr_reg[63], bus_bits};
    // The legacy mode shares descriptor zero instead of its own table sizing.
    wire logic [PART_W-1:0] part = partitioned_translation_mode ? map_reg[pid] : 5'h00;
    wire logic [ENTRY_W-1:0] desc = desc_reg[part];
    wire logic [2:0] ps = desc[DESC_PS_HI:DESC_PS_LO];
    wire logic [3:0] len = desc[DESC_LEN_HI:DESC_LEN_LO];
    wire logic [VPN_W-1:0] offset = desc[DESC_OFS_HI:DESC_OFS_LO];
    wire logic [25:0] base = desc[DESC_BASE_HI:DESC_BASE_LO];
    wire logic desc_par_err = ~^{desc[DESC_VALID:DESC_PAR_HI], desc[DESC_BASE_HI:32]}
                              | ~^{desc[DESC_PAR_LO], desc[31:0]};
    wire logic bad_granule = !(ps == 3'h0 || ps == 3'h1 || ps == 3'h3 || ps == 3'h5);
    wire logic [5:0] page_shift = 6'(PAGE_SHIFT_BASE + PAGE_SHIFT_STEP * int'(ps));
    wire logic [VA_W-1:0] va_page = va >> page_shift;
    wire logic [VPN_W:0] adj_diff = {1'b0, va_page[VPN_W-1:0]} - {1'b0, offset};
    wire logic adj_uf = adj_diff[VPN_W];
    wire logic [VPN_W-1:0] adjusted_virtual_address = adj_diff[VPN_W-1:0];
    wire logic [4:0] len_shift = 5'(TABLE_LEN_BASE) + {1'b0, len};
    wire logic [VPN_W:0] len_pages = 28'h0000001 << len_shift;
    // Page numbers run from zero, so the table length itself is already past the end.
    wire logic range_err = {1'b0, adjusted_virtual_address} >= len_pages;
    wire logic [PA_W-1:0] entry_addr = {base, 13'h0000}
                          + PA_W'({adjusted_virtual_address, 3'h0});

    // Address errors are reported one at a time in a fixed priority.
    logic [FLAG_W-1:0] addr_err;
    always_comb
    begin
        addr_err = '0;
        if (va_oor)
        begin
            addr_err[F_VA_OOR] = 1'b1;
        end
        else if (desc_par_err)
        begin
            addr_err[F_DESC_PAR] = 1'b1;
        end
        else if (!desc[DESC_VALID])
        begin
            addr_err[F_DESC_INV] = 1'b1;
        end
        else if (bad_granule)
        begin
            addr_err[F_GRANULE] = 1'b1;
        end
        else if (adj_uf)
        begin
            addr_err[F_ADJ_UF] = 1'b1;
        end
        else if (range_err)
        begin
            addr_err[F_RANGE] = 1'b1;
        end
    end

    // Entry checks run side by side on a hit or on a freshly fetched walk entry.
    wire logic [ENTRY_W-1:0] entry_sel = (state_reg == ST_VERIFY) ? entry_reg : cif.hit_entry;
    wire logic ent_inv = !entry_sel[TTE_VALID];
    wire logic ent_prot = write_reg && !entry_sel[TTE_WRITE];
    wire logic ent_key = entry_sel[TTE_KEY_EN] && (entry_sel[TTE_KEY_HI:TTE_KEY_LO] != id_reg);
    wire logic [VA_W-1:0] page_mask = (40'h0000000001 << page_shift) - 40'h0000000001;
    wire logic [PA_W-1:0] pa_calc = ({entry_sel[TTE_PPN_HI:TTE_PPN_LO], 13'h0000}
                                     & ~page_mask[PA_W-1:0]) | (va[PA_W-1:0] & page_mask[PA_W-1:0]);
    wire logic walk_lpe = ~^{walk_rsp_data, walk_rsp_par};
    wire logic walk_bad = walk_rsp_ue || walk_rsp_dpe || walk_lpe || (walk_rsp_slot != slot_reg);
    // Locked and reserved modes keep the cache contents as they are.
    wire logic may_install = (cache_mode_code == CM_FULL) || (cache_mode_code == CM_SINGLE);

    assign cif.lookup_tag = {part, adjusted_virtual_address};
    assign cif.single_line = cache_mode_code == CM_SINGLE;
    assign cif.install = (state_reg == ST_WALK) && walk_rsp_valid && !walk_bad && may_install;
    assign cif.install_tag = {part, adjusted_virtual_address};
    assign cif.install_entry = walk_rsp_data;
    assign cif.flush = flush_req;

    // Flags raised and next state for each step of a request.
    always_comb
    begin
        flag_set = '0;
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    state_next = ST_LOOKUP;
                end
            end
            ST_LOOKUP:
            begin
                state_next = ST_DONE;
                if (!translate_en)
                begin
                    flag_set[F_XLATE_OFF] = 1'b1;
                end
                else if (|addr_err)
                begin
                    flag_set = addr_err;
                end
                else if (cif.hit)
                begin
                    flag_set[F_CACHE_PAR] = cif.hit_par_err;
                    flag_set[F_TTE_INV] = ent_inv;
                    flag_set[F_PROTECT] = ent_prot;
                    flag_set[F_KEY] = ent_key;
                end
                else if (!walk_en)
                begin
                    flag_set[F_WALK_DIS] = 1'b1;
                end
                else
                begin
                    state_next = ST_WALK;
                end
            end
            ST_WALK:
            begin
                if (walk_rsp_valid)
                begin
                    flag_set[F_WALK_ERR] = walk_rsp_ue || walk_rsp_dpe;
                    flag_set[F_WALK_PAR] = walk_lpe;
                    flag_set[F_REPLACE] = walk_rsp_slot != slot_reg;
                    state_next = walk_bad ? ST_DONE : ST_VERIFY;
                end
            end
            ST_VERIFY:
            begin
                flag_set[F_TTE_INV] = ent_inv;
                flag_set[F_PROTECT] = ent_prot;
                flag_set[F_KEY] = ent_key;
                state_next = ST_DONE;
            end
            ST_DONE:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire logic finishing = (state_next == ST_DONE) && (state_reg != ST_DONE);

    assign req_ready = state_reg == ST_IDLE;
    assign resp_valid = state_reg == ST_DONE;
    assign resp_null = null_reg;
    assign resp_pa = pa_reg;
    assign walk_req_valid = walk_pulse_reg;
    assign walk_req_addr = walk_addr_reg;
    assign walk_req_slot = slot_reg;
    assign desc_rdata = rdata_reg;
    assign flags = flags_reg;

    // Sequencing, request capture and answer registers.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            null_reg <= 1'b0;
            pa_reg <= '0;
            walk_pulse_reg <= 1'b0;
            walk_addr_reg <= '0;
            slot_reg <= 8'h00;
            addr_reg <= 64'h0000000000000000;
            is64_reg <= 1'b0;
            write_reg <= 1'b0;
            id_reg <= 16'h0000;
            entry_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            walk_pulse_reg <= (state_reg == ST_LOOKUP) && (state_next == ST_WALK);
            if (state_reg == ST_IDLE && req_valid)
            begin
                addr_reg <= req_addr;
                is64_reg <= req_is64;
                write_reg <= req_write;
                id_reg <= req_id;
            end
            if (state_reg == ST_LOOKUP)
            begin
                walk_addr_reg <= entry_addr;
                slot_reg <= cif.alloc_slot;
            end
            if (state_reg == ST_WALK && walk_rsp_valid)
            begin
                entry_reg <= walk_rsp_data;
            end
            if (finishing)
            begin
                null_reg <= |flag_set;
                pa_reg <= (|flag_set) ? '0 : pa_calc;
            end
        end
    end

    // Sticky flags: a new event in the clearing cycle survives the clear.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flags_reg <= FLAGS_RESET;
        end
        else
        begin
            flags_reg <= (flags_reg & ~flag_clear) | flag_set;
        end
    end

    // Software tables; table contents have no reset, valid bits decide use.
    always_ff @(posedge clk)
    begin
        if (desc_we)
        begin
            desc_reg[desc_idx] <= {desc_wdata[DESC_VALID], par_hi, par_lo, desc_wdata[60:0]};
        end
        if (map_we)
        begin
            map_reg[map_idx] <= map_wdata;
        end
        rdata_reg <= desc_reg[desc_idx];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_flag_sticky: assert property (
        ((flags_reg & ~flag_clear) != '0) |=> ((flags & $past(flags_reg & ~flag_clear))
                                              == $past(flags_reg & ~flag_clear)))
        else $error("sticky flag lost without a clear");
    chk_oor_null: assert property (
        (state_reg == ST_LOOKUP) && translate_en && va_oor |=> resp_valid && resp_null
                                                             && flags[F_VA_OOR])
        else $error("overflowed address not nullified");
    chk_addr_priority: assert property (
        (state_reg == ST_LOOKUP) && translate_en && (va_oor || adj_uf)
        |-> !flag_set[F_RANGE] && (!va_oor || !flag_set[F_ADJ_UF]))
        else $error("address error priority broken");
    chk_walk_off: assert property (
        (state_reg == ST_LOOKUP) && translate_en && !(|addr_err) && !cif.hit && !walk_en
        |-> flag_set[F_WALK_DIS] ##1 resp_valid && resp_null)
        else $error("miss with walking off not nullified");
    chk_write_protect: assert property (
        (state_reg == ST_VERIFY) && write_reg && !entry_reg[TTE_WRITE] |=> resp_valid && resp_null)
        else $error("write to read-only page passed");
    chk_walk_issue: assert property (
        (state_reg == ST_LOOKUP) && (state_next == ST_WALK) |=> walk_req_valid ##1 !walk_req_valid)
        else $error("walk request not a single pulse");
    chk_hit_answer: assert property (
        (state_reg == ST_LOOKUP) && translate_en && !(|addr_err) && cif.hit |=> resp_valid)
        else $error("hit not answered next cycle");
    chk_single_slot: assert property (
        cif.single_line && cif.install && !cif.flush |=> cif.hit || !cif.single_line)
        else $error("single-line install not found in slot zero");
    chk_locked_keep: assert property (
        cache_mode_code == CM_LOCKED |-> !cif.install)
        else $error("locked cache was written");
    chk_desc_parity: assert property (
        desc_we |=> ^{desc_reg[$past(desc_idx)][DESC_VALID:DESC_PAR_HI],
                      desc_reg[$past(desc_idx)][DESC_BASE_HI:32]})
        else $error("descriptor parity not odd");

    cov_hit_ok: cover property ((state_reg == ST_LOOKUP) && cif.hit ##1 resp_valid && !resp_null);
    cov_walk_install: cover property (cif.install ##1 (state_reg == ST_VERIFY));
    cov_key_err: cover property (flag_set[F_KEY]);
    cov_range_err: cover property (flag_set[F_RANGE]);

endmodule : dma_translator

// ==== dma_xlate_pkg.sv ====
// Shared constants, field layouts and types for the DMA address translator.
package dma_xlate_pkg;

    // Address widths of the translation path.
    localparam int VA_W = 40;
    localparam int PA_W = 39;
    localparam int VPN_W = 27;
    localparam int PART_W = 5;
    localparam int PID_W = 7;
    localparam int TAG_W = PART_W + VPN_W;
    localparam int ENTRY_W = 64;
    localparam int DESC_COUNT = 32;
    localparam int MAP_COUNT = 128;

    // Cache mode codes.
    localparam logic [1:0] CM_SINGLE = 2'h0;
    localparam logic [1:0] CM_LOCKED = 2'h2;
    localparam logic [1:0] CM_FULL = 2'h3;
    localparam logic [1:0] CM_RESET = CM_FULL;

    // Descriptor field positions.
    localparam int DESC_VALID = 63;
    localparam int DESC_PAR_HI = 62;
    localparam int DESC_PAR_LO = 61;
    localparam int DESC_BASE_HI = 59;
    localparam int DESC_BASE_LO = 34;
    localparam int DESC_OFS_HI = 33;
    localparam int DESC_OFS_LO = 7;
    localparam int DESC_PS_HI = 6;
    localparam int DESC_PS_LO = 4;
    localparam int DESC_LEN_HI = 3;
    localparam int DESC_LEN_LO = 0;

    // Translation entry field positions.
    localparam int TTE_KEY_HI = 63;
    localparam int TTE_KEY_LO = 48;
    localparam int TTE_PPN_HI = 38;
    localparam int TTE_PPN_LO = 13;
    localparam int TTE_KEY_EN = 2;
    localparam int TTE_WRITE = 1;
    localparam int TTE_VALID = 0;

    // Size arithmetic constants.
    localparam int PAGE_SHIFT_BASE = 13;
    localparam int PAGE_SHIFT_STEP = 3;
    localparam int TABLE_LEN_BASE = 10;
    localparam int ENTRY_SHIFT = 3;
    localparam int BASE_ALIGN = 13;

    // Sticky error flag bit positions.
    localparam int FLAG_W = 15;
    localparam int F_RANGE = 0;
    localparam int F_VA_OOR = 1;
    localparam int F_ADJ_UF = 2;
    localparam int F_GRANULE = 3;
    localparam int F_CACHE_PAR = 4;
    localparam int F_TTE_INV = 5;
    localparam int F_PROTECT = 6;
    localparam int F_KEY = 7;
    localparam int F_WALK_DIS = 8;
    localparam int F_WALK_ERR = 9;
    localparam int F_WALK_PAR = 10;
    localparam int F_REPLACE = 11;
    localparam int F_DESC_PAR = 12;
    localparam int F_DESC_INV = 13;
    localparam int F_XLATE_OFF = 14;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 15'h0000;

    // Request sequencing states.
    typedef enum logic [2:0] {ST_IDLE, ST_LOOKUP, ST_WALK, ST_VERIFY, ST_DONE} xlate_state_e;

endpackage : dma_xlate_pkg

// ==== tte_cache_if.sv ====
// Carrier between the translator core and its translation entry cache.
`timescale 1ns/10ps
interface tte_cache_if;
    import dma_xlate_pkg::*;
    logic [TAG_W-1:0] lookup_tag; // Partition and adjusted page being looked up.
    logic single_line; // Only slot zero is used.
    logic hit; // Some valid slot matches the tag.
    logic [ENTRY_W-1:0] hit_entry; // Entry of the matching slot.
    logic hit_par_err; // Stored parity of the matching slot is bad.
    logic [7:0] alloc_slot; // Slot the next install will use.
    logic install; // One-cycle install strobe.
    logic [TAG_W-1:0] install_tag; // Tag to install.
    logic [ENTRY_W-1:0] install_entry; // Entry to install.
    logic flush; // Drop every cached entry.

    modport ctrl (output lookup_tag, single_line, install, install_tag, install_entry, flush,
                  input hit, hit_entry, hit_par_err, alloc_slot);
    modport store (input lookup_tag, single_line, install, install_tag, install_entry, flush,
                   output hit, hit_entry, hit_par_err, alloc_slot);
endinterface : tte_cache_if

// ==== tte_cache.sv ====
// Fully associative cache of translation entries with parity and replacement.
`timescale 1ns/10ps
module tte_cache
    import dma_xlate_pkg::*;
#(
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst_n,
    tte_cache_if.store cif
);

    logic [DEPTH-1:0] valid_reg; // Per-slot valid bits.
    logic [TAG_W-1:0] tag_reg [DEPTH]; // Tag array.
    logic [ENTRY_W-1:0] data_reg [DEPTH]; // Data array.
    logic [DEPTH-1:0] par_reg; // Odd parity bit per slot.
    logic [7:0] rr_reg; // Round-robin victim pointer.
    logic [7:0] hit_idx; // Matching slot.
    logic [7:0] free_idx; // First empty slot.
    logic free_found; // Some slot is empty.
    logic [DEPTH-1:0] match; // Per-slot tag match.

    // Every slot compares at once; single-line mode looks at slot zero only.
    always_comb
    begin
        hit_idx = 8'h00;
        free_idx = 8'h00;
        free_found = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            match[i] = valid_reg[i] && (tag_reg[i] == cif.lookup_tag)
                       && (!cif.single_line || i == 0);
            if (match[i])
            begin
                hit_idx = 8'(i);
            end
            if (!valid_reg[i])
            begin
                free_idx = 8'(i);
                free_found = 1'b1;
            end
        end
    end

    assign cif.hit = |match;
    assign cif.hit_entry = data_reg[hit_idx[$clog2(DEPTH)-1:0]];
    assign cif.hit_par_err = ~^{data_reg[hit_idx[$clog2(DEPTH)-1:0]],
                                par_reg[hit_idx[$clog2(DEPTH)-1:0]]};
    // Outside single-line mode an empty slot is used first; only a full cache evicts the pointed victim.
    assign cif.alloc_slot = cif.single_line ? 8'h00 : (free_found ? free_idx : rr_reg);

    // Install writes tag, data and parity together; flush clears all valids.
    always_ff @(posedge clk)
    begin
        if (!rst_n || cif.flush)
        begin
            valid_reg <= '0;
            rr_reg <= 8'h00;
        end
        else if (cif.install)
        begin
            valid_reg[cif.alloc_slot[$clog2(DEPTH)-1:0]] <= 1'b1;
            tag_reg[cif.alloc_slot[$clog2(DEPTH)-1:0]] <= cif.install_tag;
            data_reg[cif.alloc_slot[$clog2(DEPTH)-1:0]] <= cif.install_entry;
            par_reg[cif.alloc_slot[$clog2(DEPTH)-1:0]] <= ~^cif.install_entry;
            if (!free_found)
            begin
                rr_reg <= (rr_reg == 8'(DEPTH - 1)) ? 8'h00 : rr_reg + 8'h01;
            end
        end
    end

endmodule : tte_cache

// ==== walk_mem_model.sv ====
// Memory side model that answers translation table fetches.
`timescale 1ns/10ps
module walk_mem_model
    import dma_xlate_pkg::*;
(
    input wire logic clk,
    input wire logic walk_req_valid,
    input wire logic [PA_W-1:0] walk_req_addr,
    output logic walk_rsp_valid,
    output logic [ENTRY_W-1:0] walk_rsp_data,
    output logic walk_rsp_par
);
    localparam logic [15:0] OWNER_ID = 16'h0102; // Requester ID that owns the keyed pages.
    logic [25:0] page; // Table index doubles as the physical page.
    logic [1:0] delay_reg = 2'h0; // Two cycle delay, like a slow memory.
    logic [ENTRY_W-1:0] entry; // Entry image with the valid bit set.
    assign page = walk_req_addr[28:3];
    // Odd pages are writable; pages with bit 1 set demand the owner's requester ID.
    assign entry = {OWNER_ID, 9'h000, page, 10'h000, page[1], page[0], 1'b1};
    // Shift the fetch strobe along to make the answer late.
    always_ff @(posedge clk)
    begin
        delay_reg <= {delay_reg[0], walk_req_valid};
    end
    assign walk_rsp_valid = delay_reg[1];
    // Outside the answer the bus shows the inverse, never a stale entry.
    assign walk_rsp_data = walk_rsp_valid ? entry : ~entry;
    assign walk_rsp_par = ~^walk_rsp_data;
endmodule : walk_mem_model

// ==== test_dma_translator.sv ====
// Self-checking testbench of the DMA address translator.
`timescale 1ns/10ps
module test_dma_translator
    import dma_xlate_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, xen = 1'b1, wen = 1'b0, flush = 1'b0, req_valid = 1'b0;
    logic req_ready, resp_valid, resp_null, wrv, wsv, wpar, req_write = 1'b0, desc_we = 1'b0;
    logic [63:0] req_addr = 64'h0, desc_wdata = 64'h0, desc_rdata, wdat;
    logic [PA_W-1:0] resp_pa, wra;
    logic [7:0] slot;
    logic [FLAG_W-1:0] flags, fclr = 15'h0;
    logic is64 = 1'b1, ue = 1'b0, dpe = 1'b0;
    logic [1:0] cmode = 2'h3;
    logic [4:0] didx = 5'h0;
    logic [15:0] rid = 16'h0102;
    int num_errors = 0, compares = 0, cycles = 0;
    always #25 clk = ~clk;
    dma_translator dma_translator_i (.clk(clk), .rst_n(rst_n), .translate_en(xen),
        .walk_en(wen), .partitioned_translation_mode(1'b0), .bus_id_shift(1'b0),
        .cache_mode_code(cmode), .flush_req(flush), .req_valid(req_valid), .req_ready(req_ready),
        .req_addr(req_addr), .req_is64(is64), .req_write(req_write), .req_id(rid),
        .resp_valid(resp_valid), .resp_null(resp_null), .resp_pa(resp_pa),
        .walk_req_valid(wsv), .walk_req_addr(wra), .walk_req_slot(slot), .walk_rsp_valid(wrv),
        .walk_rsp_data(wdat), .walk_rsp_par(wpar), .walk_rsp_ue(ue), .walk_rsp_dpe(dpe),
        .walk_rsp_slot(slot), .desc_we(desc_we), .desc_idx(didx), .desc_wdata(desc_wdata),
        .desc_rdata(desc_rdata), .map_we(1'b0), .map_idx(7'h0), .map_wdata(5'h0),
        .flag_clear(fclr), .flags(flags));
    walk_mem_model walk_mem_model_i (.clk(clk), .walk_req_valid(wsv), .walk_req_addr(wra),
        .walk_rsp_valid(wrv), .walk_rsp_data(wdat), .walk_rsp_par(wpar));
    // Compare one value and count it.
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Write one descriptor, then read it back with the parity bits the hardware made.
    task automatic desc_chk(input logic [4:0] i, input logic [63:0] d, input logic [63:0] e);
        didx = i;
        desc_wdata = d;
        desc_we = 1'b1;
        @(posedge clk);
        #1 desc_we = 1'b0;
        @(posedge clk);
        #1 chk(desc_rdata, e);
    endtask : desc_chk
    // One request: expected address and flags; any flag means nullified.
    task automatic xlate(input logic [63:0] a, input logic w, input logic [PA_W-1:0] pa,
                         input logic [FLAG_W-1:0] f);
        int n;
        n = 0;
        req_addr = a;
        req_write = w;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk(resp_null, f != 15'h0);
        chk(resp_pa, pa);
        @(posedge clk);
        #1 chk(flags, f);
        fclr = 15'h7fff;
        @(posedge clk);
        #1 fclr = 15'h0;
    endtask : xlate
    // Print the verdict and stop.
    task automatic end_sim;
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Cut a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        chk(flags, 15'h0);
        desc_chk(5'h0, 64'h8000_0000_0000_0000, 64'ha000_0000_0000_0000);
        desc_chk(5'h1, 64'h8000_0000_0000_0001, 64'h8000_0000_0000_0001);
        xlate(64'ha000, 1'b0, 39'h0, 15'h1 << F_WALK_DIS);
        wen = 1'b1;
        xlate(64'ha123, 1'b0, 39'ha123, 15'h0);
        chk(wra, 39'h28);
        xlate(64'h8010, 1'b1, 39'h0, 15'h1 << F_PROTECT);
        xlate(64'ha456, 1'b1, 39'ha456, 15'h0);
        // A 32-bit request ignores the upper bits, so this one hits the cached page.
        is64 = 1'b0;
        xlate(64'h100_0000_a123, 1'b0, 39'ha123, 15'h0);
        is64 = 1'b1;
        // Page six demands the owner's ID; a foreign requester is refused.
        rid = 16'h0103;
        xlate(64'hc000, 1'b0, 39'h0, 15'h1 << F_KEY);
        rid = 16'h0102;
        ue = 1'b1;
        xlate(64'h12000, 1'b0, 39'h0, 15'h1 << F_WALK_ERR);
        ue = 1'b0;
        dpe = 1'b1;
        xlate(64'h12000, 1'b0, 39'h0, 15'h1 << F_WALK_ERR);
        dpe = 1'b0;
        // A locked cache answers from the walk but keeps nothing of it.
        cmode = 2'h2;
        xlate(64'he000, 1'b0, 39'he000, 15'h0);
        wen = 1'b0;
        xlate(64'he000, 1'b0, 39'h0, 15'h1 << F_WALK_DIS);
        // Single-line mode must not see page four, cached in slot one.
        cmode = 2'h0;
        xlate(64'h8000, 1'b0, 39'h0, 15'h1 << F_WALK_DIS);
        wen = 1'b1;
        xlate(64'h8000, 1'b0, 39'h8000, 15'h0);
        flush = 1'b1;
        @(posedge clk);
        #1 flush = 1'b0;
        cmode = 2'h3;
        wen = 1'b0;
        xlate(64'h8000, 1'b0, 39'h0, 15'h1 << F_WALK_DIS);
        xlate(64'h80_0000, 1'b0, 39'h0, 15'h1 << F_RANGE);
        xlate(64'h100_0000_0000, 1'b0, 39'h0, 15'h1 << F_VA_OOR);
        xen = 1'b0;
        xlate(64'ha000, 1'b0, 39'h0, 15'h1 << F_XLATE_OFF);
        end_sim();
    end
endmodule : test_dma_translator
